// >>> src/comm_frame_statistics.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`include "comm_stats_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module comm_frame_statistics #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic uart_cmd_ok,
  input wire logic lower_chain_port_cmd_ok,
  input wire logic upper_chain_port_resp_ok,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import comm_stats_pkg::*;

  comm_stats_pkg::stat_pair_t uart_stat;
  comm_stats_pkg::stat_pair_t lower_stat;
  comm_stats_pkg::stat_pair_t upper_stat;
  comm_stats_pkg::rd_resp_t rd_reg;
  comm_stats_pkg::rd_resp_t rd_next;

  logic rvalid_reg;
  logic bvalid_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic ar_fire;
  logic aw_got;
  logic w_got;
  logic [ADDR_WIDTH-3:0] rd_idx;
  logic snap_uart;
  logic snap_lower;
  logic snap_upper;
  logic rd_hit;
  logic [7:0] rd_byte;

  // Read channel: one read at a time, answered the cycle after the address is taken
  assign arready = !rvalid_reg;
  assign ar_fire = arvalid && arready;
  assign rd_idx = araddr[ADDR_WIDTH-1:2];

  // Snapshot fires on the address handshake, so a stalled rready cannot repeat it
  assign snap_uart = ar_fire && (rd_idx == `IDX_UART_SNAP);
  assign snap_lower = ar_fire && (rd_idx == `IDX_LOWER_SNAP);
  assign snap_upper = ar_fire && (rd_idx == `IDX_UPPER_SNAP);

  assign rd_byte = (rd_idx == `IDX_UART_HIGH) ? uart_stat.high :
                   (rd_idx == `IDX_UART_LOW) ? uart_stat.low :
                   (rd_idx == `IDX_LOWER_HIGH) ? lower_stat.high :
                   (rd_idx == `IDX_LOWER_LOW) ? lower_stat.low :
                   (rd_idx == `IDX_UPPER_HIGH) ? upper_stat.high :
                   (rd_idx == `IDX_UPPER_LOW) ? upper_stat.low :
                   `SNAP_READ_VALUE;
  assign rd_hit = (rd_idx >= `IDX_UART_HIGH && rd_idx <= `IDX_UPPER_LOW) ||
                  snap_uart || snap_lower || snap_upper;
  assign rd_next = {24'h000000, rd_hit ? rd_byte : 8'h00,
                    rd_hit ? `RESP_OKAY : `RESP_SLVERR};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rd_reg <= '0;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rd_reg <= rd_next;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata = rd_reg.data;
  assign rresp = rd_reg.resp;

  // Write channel: address and data taken in either order; every register is read-only
  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready = !w_have_reg && !bvalid_reg;
  assign aw_got = aw_have_reg || (awvalid && awready);
  assign w_got = w_have_reg || (wvalid && wready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
    end else if (aw_got && w_got) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b1;
    end else begin
      aw_have_reg <= aw_got;
      w_have_reg <= w_got;
      if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign bvalid = bvalid_reg;
  // Writes never alter a count, so they are refused outright
  assign bresp = `RESP_SLVERR;

  stat_counter #(.WIDTH(`STAT_WIDTH)) u_uart (
    .aclk(aclk),
    .aresetn(aresetn),
    .frame_ok(uart_cmd_ok),
    .snapshot(snap_uart),
    .latched(uart_stat)
  );

  stat_counter #(.WIDTH(`STAT_WIDTH)) u_lower (
    .aclk(aclk),
    .aresetn(aresetn),
    .frame_ok(lower_chain_port_cmd_ok),
    .snapshot(snap_lower),
    .latched(lower_stat)
  );

  stat_counter #(.WIDTH(`STAT_WIDTH)) u_upper (
    .aclk(aclk),
    .aresetn(aresetn),
    .frame_ok(upper_chain_port_resp_ok),
    .snapshot(snap_upper),
    .latched(upper_stat)
  );

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  read_answer_a: assert property (ar_fire |=> rvalid)
    else $error("Read not answered next cycle");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read answer dropped before rready");
  write_resp_a: assert property (awvalid && awready && wvalid && wready |=> bvalid &&
    bresp == `RESP_SLVERR) else $error("Write not refused");
  uart_read_a: assert property (ar_fire && rd_idx == `IDX_UART_HIGH |=>
    rdata == {24'h000000, $past(uart_stat.high)} && rresp == `RESP_OKAY)
    else $error("UART high byte read wrong");
  uart_snap_a: assert property (snap_uart |=> uart_stat == $past(u_uart.count_reg))
    else $error("UART snapshot wrong");
  lower_snap_a: assert property (snap_lower |=> lower_stat == $past(u_lower.count_reg))
    else $error("Lower-port snapshot wrong");
  upper_snap_a: assert property (snap_upper |=> upper_stat == $past(u_upper.count_reg))
    else $error("Upper-port snapshot wrong");
  group_iso_a: assert property (snap_uart |=> $stable(lower_stat) && $stable(upper_stat))
    else $error("Snapshot disturbed another group");
  lower_iso_a: assert property (snap_lower |=>
    $stable(uart_stat) && $stable(upper_stat))
    else $error("Lower-port snapshot disturbed another group");
  upper_iso_a: assert property (snap_upper |=>
    $stable(uart_stat) && $stable(lower_stat))
    else $error("Upper-port snapshot disturbed another group");
  uart_restart_a: assert property (snap_uart |=>
    u_uart.count_reg == {15'h0000, $past(uart_cmd_ok)})
    else $error("UART count did not restart");
  lower_restart_a: assert property (snap_lower |=>
    u_lower.count_reg == {15'h0000, $past(lower_chain_port_cmd_ok)})
    else $error("Lower-port count did not restart");
  upper_restart_a: assert property (snap_upper |=>
    u_upper.count_reg == {15'h0000, $past(upper_chain_port_resp_ok)})
    else $error("Upper-port count did not restart");

  // Byte reads show the latched pair, never the live count
  uart_low_a: assert property (ar_fire && rd_idx == `IDX_UART_LOW |=>
    rdata == {24'h000000, $past(uart_stat.low)} && rresp == `RESP_OKAY)
    else $error("UART low byte read wrong");
  lower_high_a: assert property (ar_fire && rd_idx == `IDX_LOWER_HIGH |=>
    rdata == {24'h000000, $past(lower_stat.high)} && rresp == `RESP_OKAY)
    else $error("Lower-port high byte read wrong");
  lower_low_a: assert property (ar_fire && rd_idx == `IDX_LOWER_LOW |=>
    rdata == {24'h000000, $past(lower_stat.low)} && rresp == `RESP_OKAY)
    else $error("Lower-port low byte read wrong");
  upper_high_a: assert property (ar_fire && rd_idx == `IDX_UPPER_HIGH |=>
    rdata == {24'h000000, $past(upper_stat.high)} && rresp == `RESP_OKAY)
    else $error("Upper-port high byte read wrong");
  upper_low_a: assert property (ar_fire && rd_idx == `IDX_UPPER_LOW |=>
    rdata == {24'h000000, $past(upper_stat.low)} && rresp == `RESP_OKAY)
    else $error("Upper-port low byte read wrong");
  snap_read_a: assert property (snap_uart || snap_lower || snap_upper |=>
    rdata == {24'h000000, `SNAP_READ_VALUE} && rresp == `RESP_OKAY)
    else $error("Snapshot register read wrong");
  unmapped_a: assert property (ar_fire && !rd_hit |=>
    rdata == 32'h00000000 && rresp == `RESP_SLVERR) else $error("Unmapped read not refused");
  write_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("Write response dropped before bready");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("Read address taken while answer pending");
  reset_zero_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
    uart_stat == '0 && lower_stat == '0 && upper_stat == '0)
    else $error("Counts not zero after reset");

  snap_uart_c: cover property (snap_uart ##1 rvalid && rready);
  snap_lower_c: cover property (snap_lower);
  write_back_c: cover property (bvalid && bready);
  read_stall_c: cover property (rvalid && !rready ##1 rvalid && rready);

endmodule

`default_nettype wire

// >>> src/comm_stats_regs.svh
`ifndef COMM_STATS_REGS_SVH
`define COMM_STATS_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_UART_HIGH 10'h26b
`define IDX_UART_LOW 10'h26c
`define IDX_LOWER_HIGH 10'h26d
`define IDX_LOWER_LOW 10'h26e
`define IDX_UPPER_HIGH 10'h26f
`define IDX_UPPER_LOW 10'h270
`define IDX_UART_SNAP 10'h280
`define IDX_LOWER_SNAP 10'h281
`define IDX_UPPER_SNAP 10'h282

`define STAT_WIDTH 16
`define STAT_RESET 8'h00
`define SNAP_READ_VALUE 8'h00

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> src/comm_stats_pkg.sv
package comm_stats_pkg;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } stat_pair_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } rd_resp_t;

endpackage

// >>> src/stat_counter.sv
`timescale 1ns/100ps
`default_nettype none

module stat_counter #(
  parameter int WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_ok,
  input wire logic snapshot,
  output logic [WIDTH-1:0] latched
);

  localparam logic [WIDTH-1:0] FULL = '1;
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] latched_reg;
  logic at_full;
  logic [WIDTH-1:0] bumped;
  logic [WIDTH-1:0] restart;

  assign at_full = (count_reg == FULL);
  assign bumped = count_reg + ONE;
  // A frame arriving with the snapshot starts the new interval, so it is not lost
  assign restart = {{(WIDTH-1){1'b0}}, frame_ok};
  assign count_next = snapshot ? restart :
                      (frame_ok && !at_full) ? bumped :
                      count_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
      latched_reg <= '0;
    end else begin
      count_reg <= count_next;
      if (snapshot) begin
        latched_reg <= count_reg;
      end
    end
  end

  assign latched = latched_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  count_step_a: assert property (frame_ok && !snapshot && !at_full |=>
    count_reg == $past(count_reg) + ONE) else $error("Counter missed a frame");
  count_sat_a: assert property (at_full && !snapshot |=> count_reg == FULL)
    else $error("Counter wrapped past full scale");
  snap_latch_a: assert property (snapshot |=>
    latched_reg == $past(count_reg) && count_reg == $past(restart))
    else $error("Snapshot did not latch and restart");
  latch_hold_a: assert property (!snapshot |=> $stable(latched_reg))
    else $error("Latched value moved without snapshot");
  idle_hold_a: assert property (!snapshot && !frame_ok |=> $stable(count_reg))
    else $error("Counter moved with no frame");

  sat_reach_c: cover property (at_full && frame_ok);

endmodule

`default_nettype wire

// >>> verification/frame_source.sv
`timescale 1ns/100ps
`default_nettype none

module frame_source (
  output logic [2:0] frame_ok,
  input wire logic aclk
);
  // Bit 0 host link, bit 1 lower port, bit 2 upper port
  initial frame_ok = 3'h0;

  // Back to back pulses: one frame a cycle, the densest traffic a line can carry
  task automatic send(input logic [2:0] sel, input int n);
    repeat (n) begin
      @(posedge aclk);
      frame_ok <= sel;
    end
    @(posedge aclk);
    frame_ok <= 3'h0;
  endtask
endmodule

`default_nettype wire

// >>> verification/comm_frame_statistics_tb_top.sv
`include "comm_stats_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module comm_frame_statistics_tb_top;
  logic aclk, awready, wready, bvalid, arready, rvalid;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rd_r;
  wire [2:0] ok;
  int num_errors = 0, compares = 0;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  frame_source i_src (.frame_ok(ok), .aclk(aclk));

  comm_frame_statistics i_dut (
    .aclk(aclk), .aresetn(aresetn), .uart_cmd_ok(ok[0]),
    .lower_chain_port_cmd_ok(ok[1]), .upper_chain_port_resp_ok(ok[2]),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  // Look just after the edge so the ready or valid seen is the one the next edge samples
  task automatic wt(input int k);
    bit h = 1'b0;
    for (int i = 0; i < 50 && !h; i++) begin
      #1;
      h = k == 0 ? arready === 1'b1 : k == 1 ? rvalid === 1'b1 :
          k == 2 ? bvalid === 1'b1 : awready === 1'b1 && wready === 1'b1;
      rd_d = rdata;
      rd_r = k == 2 ? bresp : rresp;
      @(posedge aclk);
    end
    if (!h) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wt(0);
    arvalid <= 1'b0;
    wt(1);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a);
    @(posedge aclk);
    awaddr <= a;
    wdata <= 32'hffffffff;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wt(3);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wt(2);
    bready <= 1'b0;
  endtask

  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    rd(a);
    chk(n, rd_d, e);
    chk({n, " resp"}, {30'h0, rd_r}, {30'h0, r});
  endtask

  task automatic grp(input logic [9:0] ix, input logic [15:0] e);
    rc("high", {ix, 2'b00}, {24'h0, e[15:8]}, `RESP_OKAY);
    rc("low", {ix + 10'h1, 2'b00}, {24'h0, e[7:0]}, `RESP_OKAY);
  endtask

  task automatic snap(input logic [9:0] ix);
    rc("snapshot", {ix, 2'b00}, {24'h0, `SNAP_READ_VALUE}, `RESP_OKAY);
  endtask

  task automatic s_reset;
    for (int k = 0; k < 6; k++) begin
      rc("reset", {`IDX_UART_HIGH + k[9:0], 2'b00}, 32'h0, `RESP_OKAY);
    end
  endtask

  task automatic s_count;
    i_src.send(3'b111, 3);
    i_src.send(3'b110, 2);
    i_src.send(3'b100, 2);
    snap(`IDX_UART_SNAP);
    grp(`IDX_UART_HIGH, 16'h0003);
    grp(`IDX_LOWER_HIGH, 16'h0000);
    snap(`IDX_LOWER_SNAP);
    grp(`IDX_LOWER_HIGH, 16'h0005);
    snap(`IDX_UPPER_SNAP);
    grp(`IDX_UPPER_HIGH, 16'h0007);
    snap(`IDX_UART_SNAP);
    grp(`IDX_UART_HIGH, 16'h0000);
    grp(`IDX_LOWER_HIGH, 16'h0005);
  endtask

  task automatic s_write;
    wr({`IDX_UART_LOW, 2'b00});
    chk("write resp", {30'h0, rd_r}, {30'h0, `RESP_SLVERR});
    grp(`IDX_UART_HIGH, 16'h0000);
    rc("unmapped", {10'h271, 2'b00}, 32'h0, `RESP_SLVERR);
  endtask

  // Long run: frames past full scale on every line at once, so a wrap would show
  task automatic s_sat;
    i_src.send(3'b111, 65537);
    snap(`IDX_UART_SNAP);
    snap(`IDX_LOWER_SNAP);
    snap(`IDX_UPPER_SNAP);
    grp(`IDX_UART_HIGH, 16'hffff);
    grp(`IDX_LOWER_HIGH, 16'hffff);
    grp(`IDX_UPPER_HIGH, 16'hffff);
  endtask

  // Reset in mid-run must clear the UART latched pair and the live counts of all three lines
  task automatic s_mid_reset;
    i_src.send(3'b111, 4);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    grp(`IDX_UART_HIGH, 16'h0000);
    snap(`IDX_UART_SNAP);
    snap(`IDX_LOWER_SNAP);
    snap(`IDX_UPPER_SNAP);
    grp(`IDX_UART_HIGH, 16'h0000);
    grp(`IDX_LOWER_HIGH, 16'h0000);
    grp(`IDX_UPPER_HIGH, 16'h0000);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_count();
    s_write();
    s_sat();
    s_mid_reset();
    stop_test();
  end
endmodule

`default_nettype wire
